// ---- limit_input_sync.sv ----
// three-flop synchroniser with agreement filter for one limit pin
`default_nettype none
module limit_input_sync
(
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // pin side
    input  wire logic pin_i,
    // synchronous side
    output logic      level_o
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    always_comb
    begin
        stage_next = {stage_reg[1:0], pin_i};
        level_next = level_reg;
        // first stage feeds only the second; two and three must agree
        if (stage_reg[1] == stage_reg[2])
        begin
            level_next = stage_reg[2];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stage_reg <= 3'h0;
            level_reg <= overrun_limit_pkg::RESET_LEVEL;
        end
        else
        begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;
endmodule
`default_nettype wire

// ---- limit_switch_model.sv ----
// limit switch model driving one limit pin
`default_nettype none
module limit_switch_model
(
    // clock
    input  wire logic clock_i,
    // bench side
    input  wire logic press_i,
    input  wire logic active_high_i,
    // pin side
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_reg = 2'h0;
    // a touch stays active two clocks after release, so a one-clock tap lasts three clocks
    always_ff @(posedge clock_i)
    begin
        hold_reg <= press_i ? 2'h2 : (hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0);
    end
    assign pin_o = (press_i || hold_reg != 2'h0) ? active_high_i : !active_high_i;
endmodule
`default_nettype wire

// ---- overrun_limit_chk.sv ----
// port assertions for the over-run limit stop
`default_nettype none
module overrun_limit_chk
(
    // clock and reset
    input wire logic       clock_i,
    input wire logic       rst_i,
    // inputs
    input wire logic       axis_plus_overrun_input_i,
    input wire logic       plus_enable_i,
    input wire logic       plus_instant_i,
    input wire logic       minus_enable_i,
    input wire logic       minus_instant_i,
    input wire logic       driving_i,
    input wire logic       drive_dir_i,
    input wire logic       error_clear_i,
    // outputs
    input wire logic       decel_stop_o,
    input wire logic       instant_stop_o,
    input wire logic       plus_hw_limit_error_flag_o,
    input wire logic       minus_hw_limit_error_flag_o,
    input wire logic [1:0] input_status_level_o,
    input wire logic       plus_limit_active_o,
    input wire logic       minus_limit_active_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire hit_p = driving_i && drive_dir_i == overrun_limit_pkg::DIR_PLUS
                 && plus_enable_i && plus_limit_active_o;
    wire hit_m = driving_i && drive_dir_i == overrun_limit_pkg::DIR_MINUS
                 && minus_enable_i && minus_limit_active_o;
    // six quiet samples cover the synchroniser latency
    sequence pin_settled;
        $stable(axis_plus_overrun_input_i)[*6];
    endsequence
    ////////////////////////////////////////////////////////////
    plus_stop_a: assert property (hit_p |=> ($past(plus_instant_i) ? instant_stop_o : decel_stop_o))
        else $error("plus stop missing");
    minus_stop_a: assert property (hit_m |=> ($past(minus_instant_i) ? instant_stop_o : decel_stop_o))
        else $error("minus stop missing");
    plus_flag_a: assert property (hit_p |=> plus_hw_limit_error_flag_o)
        else $error("plus flag not set");
    minus_flag_a: assert property (hit_m |=> minus_hw_limit_error_flag_o)
        else $error("minus flag not set");
    idle_stop_a: assert property (!hit_p && !hit_m |=> !decel_stop_o && !instant_stop_o)
        else $error("stop without hit");
    flag_hold_a: assert property (plus_hw_limit_error_flag_o && !error_clear_i |=> plus_hw_limit_error_flag_o)
        else $error("plus flag dropped");
    flag_clear_a: assert property (error_clear_i && !hit_p && !hit_m |=> !plus_hw_limit_error_flag_o && !minus_hw_limit_error_flag_o)
        else $error("flags not cleared");
    pin_status_a: assert property (pin_settled |-> input_status_level_o[0] == axis_plus_overrun_input_i)
        else $error("status level wrong");
endmodule
`default_nettype wire

// ---- overrun_limit_pkg.sv ----
// constants for the over-run limit block
`default_nettype none
package overrun_limit_pkg;
    // samples of a pin: three flops, change taken when stages two and three agree
    localparam int SYNC_STAGES      = 3;
    // least active width on a limit pin that the agreement filter recognises
    localparam int MIN_ACTIVE_CLK   = 2;
    // reset values of the held state
    localparam logic RESET_FLAG     = 1'b0;
    localparam logic RESET_LEVEL    = 1'b0;
    // drive direction codes
    localparam logic DIR_PLUS       = 1'b0;
    localparam logic DIR_MINUS      = 1'b1;
    // stop kind codes
    localparam logic STOP_DECEL     = 1'b0;
    localparam logic STOP_INSTANT   = 1'b1;
    // bit positions in the live input level word
    localparam int LEVEL_PLUS_BIT   = 0;
    localparam int LEVEL_MINUS_BIT  = 1;
endpackage
`default_nettype wire

// ---- overrun_limit_stop.sv ----
// per-axis over-run limit stop, error flags and input status
`default_nettype none
module overrun_limit_stop
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // limit pins
    input  wire logic       axis_plus_overrun_input_i,
    input  wire logic       axis_minus_overrun_input_i,
    // configuration from command registers
    input  wire logic       plus_enable_i,
    input  wire logic       plus_instant_i,
    input  wire logic       plus_active_high_i,
    input  wire logic       minus_enable_i,
    input  wire logic       minus_instant_i,
    input  wire logic       minus_active_high_i,
    // drive state from the pulse generator
    input  wire logic       driving_i,
    input  wire logic       drive_dir_i,
    // error flag clear from software
    input  wire logic       error_clear_i,
    // stop requests to the pulse generator
    output logic            decel_stop_o,
    output logic            instant_stop_o,
    // status
    output logic            plus_hw_limit_error_flag_o,
    output logic            minus_hw_limit_error_flag_o,
    output logic [1:0]      input_status_level_o,
    // home search references
    output logic            plus_limit_active_o,
    output logic            minus_limit_active_o
);
    // vectors are indexed by the status word's bit positions
    localparam int N_DIR = 2;
    localparam int P     = overrun_limit_pkg::LEVEL_PLUS_BIT;
    localparam int M     = overrun_limit_pkg::LEVEL_MINUS_BIT;

    // per-direction views of the ports
    logic [N_DIR-1:0] pin_vec;
    logic [N_DIR-1:0] enable_vec;
    logic [N_DIR-1:0] instant_vec;
    logic [N_DIR-1:0] active_high_vec;
    logic [N_DIR-1:0] dir_code_vec;

    // filtered levels and polarity-corrected state
    logic [N_DIR-1:0] level_vec;
    logic [N_DIR-1:0] active_vec;

    // enabled active limit in the drive's own direction
    logic [N_DIR-1:0] hit_vec;

    // held state
    logic [N_DIR-1:0] flag_reg;
    logic [N_DIR-1:0] flag_next;
    logic             decel_reg;
    logic             decel_next;
    logic             instant_reg;
    logic             instant_next;

    ////////////////////////////////////////////////////////////////////////
    // the per-direction logic assumes two distinct bits of a two-bit word
    if (P == M || P >= N_DIR || M >= N_DIR)
    begin : g_bad_bits
        $error("limit status bit positions must be 0 and 1");
    end

    // the synchroniser is written for exactly three stages
    if (overrun_limit_pkg::SYNC_STAGES != 3)
    begin : g_bad_sync
        $error("limit synchroniser is built for three stages");
    end

    // agreement of two samples is what sets the least active width
    if (overrun_limit_pkg::MIN_ACTIVE_CLK != 2)
    begin : g_bad_width
        $error("agreement filter recognises two-clock pulses only");
    end

    ////////////////////////////////////////////////////////////////////////
    assign pin_vec[P]         = axis_plus_overrun_input_i;
    assign pin_vec[M]         = axis_minus_overrun_input_i;

    assign enable_vec[P]      = plus_enable_i;
    assign enable_vec[M]      = minus_enable_i;

    assign instant_vec[P]     = plus_instant_i;
    assign instant_vec[M]     = minus_instant_i;

    assign active_high_vec[P] = plus_active_high_i;
    assign active_high_vec[M] = minus_active_high_i;

    assign dir_code_vec[P]    = overrun_limit_pkg::DIR_PLUS;
    assign dir_code_vec[M]    = overrun_limit_pkg::DIR_MINUS;

    ////////////////////////////////////////////////////////////////////////
    for (genvar d = 0; d < N_DIR; d++)
    begin : g_dir
        // the agreement needs two equal samples, so shorter pulses may be missed
        limit_input_sync limit_input_sync_i
        (
            .clock_i (clock_i),
            .rst_i   (rst_i),
            .pin_i   (pin_vec[d]),
            .level_o (level_vec[d])
        );

        assign active_vec[d] = level_vec[d] == active_high_vec[d];

        // only the limit in the drive's own direction counts
        assign hit_vec[d] = enable_vec[d]
                            && active_vec[d]
                            && driving_i
                            && drive_dir_i == dir_code_vec[d];
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        flag_next    = flag_reg;
        decel_next   = 1'b0;
        instant_next = 1'b0;

        for (int k = 0; k < N_DIR; k++)
        begin
            if (error_clear_i)
            begin
                flag_next[k] = 1'b0;
            end

            // set wins over a clear in the same cycle
            if (hit_vec[k])
            begin
                flag_next[k] = 1'b1;

                if (instant_vec[k] == overrun_limit_pkg::STOP_INSTANT)
                begin
                    instant_next = 1'b1;
                end
                else
                begin
                    decel_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flag_reg    <= {N_DIR{overrun_limit_pkg::RESET_FLAG}};
            decel_reg   <= overrun_limit_pkg::RESET_FLAG;
            instant_reg <= overrun_limit_pkg::RESET_FLAG;
        end
        else
        begin
            flag_reg    <= flag_next;
            decel_reg   <= decel_next;
            instant_reg <= instant_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stop requests hold while the condition holds; the drive drops driving_i when stopped
    assign decel_stop_o                = decel_reg;
    assign instant_stop_o              = instant_reg;

    assign plus_hw_limit_error_flag_o  = flag_reg[P];
    assign minus_hw_limit_error_flag_o = flag_reg[M];

    // raw filtered levels, not polarity corrected
    assign input_status_level_o        = level_vec;

    // usable by home search whether or not protection is enabled
    assign plus_limit_active_o         = active_vec[P];
    assign minus_limit_active_o        = active_vec[M];
endmodule
`default_nettype wire

// ---- overrun_limit_stop_test.sv ----
// bench for the over-run limit stop with two switch models
`default_nettype none
module overrun_limit_stop_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, rst_i = 1'b1, driving_i = 1'b0, drive_dir_i = 1'b0, error_clear_i = 1'b0;
    logic plus_enable_i = 1'b0, plus_instant_i = 1'b0, plus_active_high_i = 1'b1;
    logic minus_enable_i = 1'b0, minus_instant_i = 1'b0, minus_active_high_i = 1'b1;
    logic press_p = 1'b0, press_m = 1'b0, decel_stop_o, instant_stop_o, plus_limit_active_o;
    logic plus_hw_limit_error_flag_o, minus_hw_limit_error_flag_o, minus_limit_active_o;
    logic [1:0] input_status_level_o;
    wire logic axis_plus_overrun_input_i, axis_minus_overrun_input_i;
    int n_errors = 0, n_compared = 0, cycles = 0;
    overrun_limit_stop overrun_limit_stop_i (.*);
    limit_switch_model limit_switch_model_i (.clock_i(clock_i), .press_i(press_p),
        .active_high_i(plus_active_high_i), .pin_o(axis_plus_overrun_input_i));
    limit_switch_model limit_switch_model_m_i (.clock_i(clock_i), .press_i(press_m),
        .active_high_i(minus_active_high_i), .pin_o(axis_minus_overrun_input_i));
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // config changes only while idle: a new polarity on a stale level looks like a hit
    task automatic run(input logic d, input logic s, input logic e, input logic i, input logic a);
        logic x;
        x = e && (s == d);
        @(posedge clock_i);
        {plus_enable_i, minus_enable_i, plus_instant_i, minus_instant_i} <= {e, e, i, i};
        {plus_active_high_i, minus_active_high_i} <= {a, a};
        wt(6);
        {driving_i, drive_dir_i, press_m, press_p} <= {1'b1, d, s, !s};
        wt(7);
        #1;
        chk({instant_stop_o, decel_stop_o}, x ? {i, !i} : 2'h0);
        chk({minus_hw_limit_error_flag_o, plus_hw_limit_error_flag_o}, x ? {s, !s} : 2'h0);
        chk(input_status_level_o, {s, !s} ~^ {a, a});
        chk({minus_limit_active_o, plus_limit_active_o}, {s, !s});
        @(posedge clock_i);
        {press_p, press_m, driving_i} <= 3'h0;
        wt(7);
        #1;
        chk({instant_stop_o, decel_stop_o}, 2'h0);
        chk({minus_hw_limit_error_flag_o, plus_hw_limit_error_flag_o}, x ? {s, !s} : 2'h0);
        @(posedge clock_i);
        error_clear_i <= 1'b1;
        @(posedge clock_i);
        error_clear_i <= 1'b0;
        wt(1);
        #1;
        chk({minus_hw_limit_error_flag_o, plus_hw_limit_error_flag_o}, 2'h0);
    endtask
    initial
    begin
        wt(6);
        rst_i <= 1'b0;
        wt(2);
        #1;
        chk({plus_hw_limit_error_flag_o, decel_stop_o}, 2'h0);
        for (int k = 0; k < 16; k++) run(k[0], k[1], 1'b1, k[2], k[3]);
        run(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        test_done();
    end
endmodule
bind overrun_limit_stop overrun_limit_chk overrun_limit_chk_i (.*);
`default_nettype wire
